// File: logic/acc_mux_decode.sv
`timescale 1ns/100ps
`default_nettype none

module acc_mux_decode (
	// Clock and reset.
	input  wire logic             mclk,
	input  wire logic             reset,
	// Selection in.
	input  wire logic             load,
	input  wire logic [5:0]       channel_gain_select,
	// Decoded selection out.
	output acc_pkg::acc_mux_t     mux_q
);

	acc_pkg::acc_mux_t mux_d;
	logic [5:0]        pair;

	always_comb begin
		pair = acc_pkg::DIFF_PAIR_TABLE[channel_gain_select[4:1]];
		mux_d = '0;
		mux_d.kind = acc_pkg::KIND_SINGLE;
		if (channel_gain_select[5:3] == 3'h0) begin
			mux_d.pos = channel_gain_select[2:0]; // [RULE2]
		end else if (channel_gain_select[5] == 1'b0) begin
			mux_d.kind = acc_pkg::KIND_DIFF; // [RULE4] [RULE10]
			mux_d.pos = pair[5:3];
			mux_d.neg = pair[2:0];
			mux_d.gain20 = channel_gain_select[0]; // [RULE7]
		end else if (channel_gain_select[4:3] != 2'h0) begin
			mux_d.kind = acc_pkg::KIND_DIFF; // [RULE6] [RULE8]
			mux_d.pos = pair[2:0];
			mux_d.neg = pair[5:3];
			mux_d.gain20 = channel_gain_select[0]; // [RULE7]
			mux_d.reversed = 1'b1;
		end else begin
			case (channel_gain_select)
				acc_pkg::SEL_GROUND: begin
					mux_d.kind = acc_pkg::KIND_GROUND; // [RULE2]
				end
				acc_pkg::SEL_VREF: begin
					mux_d.kind = acc_pkg::KIND_VREF; // [RULE2]
				end
				acc_pkg::SEL_TEMP: begin
					mux_d.kind = acc_pkg::KIND_TEMP; // [RULE3]
					mux_d.temp_sensor_en = 1'b1;
				end
				default: begin
					// Only 100011 to 100111 remain; the same input drives both terminals.
					mux_d.kind = acc_pkg::KIND_OFFSET; // [RULE5] [RULE9]
					mux_d.gain20 = channel_gain_select[0];
					case (channel_gain_select[2:1])
						2'h1: mux_d.pos = acc_pkg::OFS_IN_A;
						2'h2: mux_d.pos = acc_pkg::OFS_IN_B;
						default: mux_d.pos = acc_pkg::OFS_IN_C;
					endcase
					mux_d.neg = mux_d.pos;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			mux_q <= '0;
		end else if (load) begin
			mux_q <= mux_d;
		end
	end

endmodule

`default_nettype wire

// File: logic/acc_pkg.sv
// Summary of operation
// RULE1: Selection changes wait for running conversion's end.
// RULE2: Codes 0-7 single-ended; 32 ground; 33 reference.
// RULE3: Code 34 selects temperature channel, enables sensor.
// RULE4: Codes 8 to 31 are normal differential pairs.
// RULE5: Codes 35 to 39 are offset calibration only.
// RULE6: Codes 40 to 63 are reversed differential pairs.
// RULE7: Lowest select bit picks 1x or 20x gain.
// RULE8: Top select bit swaps differential pair polarity.
// RULE9: Offset calibration ties inputs 0, 3, 7 together.
// RULE10: Each differential code maps to fixed input pair.
// RULE11: Software relaunches long conversion after differential change.
// RULE12: Software waits 1ms after selecting internal reference.
// RULE13: Enable powers converter; clearing it aborts conversion.
// RULE14: Start launches one conversion; free running continues.
// RULE15: First conversion 25 converter clocks, later 13.
// RULE16: Start reads one while busy; writing zero ignored.
// RULE17: Done flag set at end; cleared by one or vector.
// RULE18: Auto trigger starts conversion on trigger rising edge.

package acc_pkg;

	// ****************************************************************
	// Register map, word indices; byte address is four times the index.
	// ****************************************************************
	localparam logic [5:0] IDX_CSR_A     = 6'h06;
	localparam logic [5:0] IDX_CHAN      = 6'h07;
	localparam logic [5:0] IDX_TRIG      = 6'h08;
	localparam logic [5:0] IDX_IRQ_STAT  = 6'h09;
	localparam logic [5:0] IDX_IRQ_CLEAR = 6'h0a;
	localparam logic [5:0] IDX_IRQ_EN    = 6'h0b;

	localparam logic [7:0] CSR_A_RESET   = 8'h00;
	localparam logic [7:0] CHAN_RESET    = 8'h00;
	localparam logic [7:0] BYTE_RESET    = 8'h00;

	// ****************************************************************
	// Field positions.
	// ****************************************************************
	localparam int CSR_EN_BIT    = 7;
	localparam int CSR_START_BIT = 6;
	localparam int CSR_AUTO_BIT  = 5;
	localparam int CSR_DONE_BIT  = 4;
	localparam int TRIG_FREE_BIT = 0;
	localparam int IRQ_DONE_BIT  = 0;
	localparam int IRQ_ABORT_BIT = 1;
	localparam int IRQ_W         = 2;
	localparam int SEL_W         = 6;

	// ****************************************************************
	// Conversion timing: lengths in converter clock cycles, divider in mclk cycles per converter clock.
	// ****************************************************************
	localparam logic [4:0] LEN_FIRST  = 5'h19;
	localparam logic [4:0] LEN_NORMAL = 5'h0d;
	localparam int         ADC_CLK_DIV_DEFAULT = 2;

	// ****************************************************************
	// Selection codes.
	// ****************************************************************
	localparam logic [5:0] SEL_GROUND = 6'h20;
	localparam logic [5:0] SEL_VREF   = 6'h21;
	localparam logic [5:0] SEL_TEMP   = 6'h22;
	localparam logic [5:0] SEL_OFS_LO = 6'h23;
	localparam logic [5:0] SEL_OFS_HI = 6'h27;
	localparam logic [2:0] OFS_IN_A   = 3'h0;
	localparam logic [2:0] OFS_IN_B   = 3'h3;
	localparam logic [2:0] OFS_IN_C   = 3'h7;

	// Normal pairs indexed by select bits 4:1, entry {positive, negative}.
	localparam logic [15:0][5:0] DIFF_PAIR_TABLE = {
		6'h37, 6'h2e, 6'h25, 6'h1f, 6'h1e, 6'h1d, 6'h1c, 6'h13,
		6'h0b, 6'h0a, 6'h03, 6'h01, 6'h00, 6'h00, 6'h00, 6'h00
	};

	// ****************************************************************
	// Types.
	// ****************************************************************
	typedef enum logic [2:0] {
		KIND_SINGLE = 3'b000,
		KIND_GROUND = 3'b001,
		KIND_VREF   = 3'b010,
		KIND_TEMP   = 3'b011,
		KIND_DIFF   = 3'b100,
		KIND_OFFSET = 3'b101
	} acc_kind_t;

	typedef struct packed {
		acc_kind_t  kind;
		logic [2:0] pos;
		logic [2:0] neg;
		logic       gain20;
		logic       temp_sensor_en;
		logic       reversed;
	} acc_mux_t;

	typedef struct packed {
		logic power;
		logic start;
		logic busy;
		logic init;
		logic done;
	} acc_conv_t;

	typedef enum logic [0:0] {
		ST_IDLE    = 1'b0,
		ST_CONVERT = 1'b1
	} acc_state_t;

endpackage

// File: logic/acc_top.sv
`timescale 1ns/100ps
`default_nettype none

module acc_top #(
	parameter int ADC_CLK_DIV = acc_pkg::ADC_CLK_DIV_DEFAULT
) (
	// Clock and reset.
	input  wire logic             mclk,
	input  wire logic             reset,
	// Wishbone classic slave.
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [7:0]       wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic [31:0]           wb_dat_o,
	output logic                  wb_ack_o,
	// Trigger and interrupt.
	input  wire logic             trigger_in,
	input  wire logic             vector_taken,
	output logic                  irq,
	// Analog multiplexer and conversion core.
	output acc_pkg::acc_mux_t     mux_sel,
	output acc_pkg::acc_conv_t    conv
);

	// ****************************************************************
	// Bus slave.
	// ****************************************************************
	logic        ack_q;
	logic [31:0] rdat_q;
	logic        access;
	logic        wr_en;
	logic [5:0]  idx;
	logic [7:0]  wdat;

	// Control registers.
	logic                         en_q;
	logic                         auto_q;
	logic                         done_q;
	logic [3:0]                   csr_low_q;
	logic [7:0]                   chan_q;
	logic                         free_run_q;
	logic [acc_pkg::IRQ_W-1:0]    stat_q;
	logic [acc_pkg::IRQ_W-1:0]    irq_en_q;

	// Conversion engine.
	acc_pkg::acc_state_t state_q;
	logic [4:0]          cnt_q;
	logic [4:0]          len_q;
	logic                first_q;
	logic [7:0]          div_q;
	logic                tick;
	logic                busy;
	logic                wr_csr;
	logic                en_next;
	logic                en_rise;
	logic                sw_start;
	logic                auto_start;
	logic                free_start;
	logic                abort;
	logic                finish;
	logic                start_go;
	logic                trig_meta_q;
	logic                trig_sync_q;
	logic                trig_prev_q;
	logic                trig_edge;
	logic                start_q;
	logic                init_q;
	logic                finish_q;
	logic                load;

	assign access = wb_cyc_i & wb_stb_i;
	assign idx    = wb_adr_i[7:2];
	assign wdat   = wb_dat_i[7:0];
	// Writes commit on the edge at which the master sees ack.
	assign wr_en  = access & wb_we_i & ack_q & wb_sel_i[0];
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	always_ff @(posedge mclk) begin
		if (reset) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= access & ~ack_q;
		end
	end

	// Unmapped and write-only words read as zero.
	always_ff @(posedge mclk) begin
		if (reset) begin
			rdat_q <= 32'h0000_0000;
		end else if (access & ~ack_q) begin
			rdat_q <= 32'h0000_0000;
			case (idx)
				acc_pkg::IDX_CSR_A: begin
					rdat_q[7:0] <= {en_q, busy, auto_q, done_q, csr_low_q}; // [RULE16]
				end
				acc_pkg::IDX_CHAN: begin
					rdat_q[7:0] <= chan_q;
				end
				acc_pkg::IDX_TRIG: begin
					rdat_q[acc_pkg::TRIG_FREE_BIT] <= free_run_q;
				end
				acc_pkg::IDX_IRQ_STAT: begin
					rdat_q[acc_pkg::IRQ_W-1:0] <= stat_q;
				end
				acc_pkg::IDX_IRQ_EN: begin
					rdat_q[acc_pkg::IRQ_W-1:0] <= irq_en_q;
				end
				default: begin
					rdat_q <= 32'h0000_0000;
				end
			endcase
		end
	end

	// ****************************************************************
	// Register writes.
	// ****************************************************************
	assign wr_csr = wr_en & (idx == acc_pkg::IDX_CSR_A);

	always_ff @(posedge mclk) begin
		if (reset) begin
			en_q      <= acc_pkg::CSR_A_RESET[acc_pkg::CSR_EN_BIT];
			auto_q    <= acc_pkg::CSR_A_RESET[acc_pkg::CSR_AUTO_BIT];
			csr_low_q <= acc_pkg::CSR_A_RESET[3:0];
		end else if (wr_csr) begin
			en_q      <= wdat[acc_pkg::CSR_EN_BIT]; // [RULE13]
			auto_q    <= wdat[acc_pkg::CSR_AUTO_BIT];
			csr_low_q <= wdat[3:0];
		end
	end

	// The selection register may change any time; the engine only samples it while idle or at a start.
	always_ff @(posedge mclk) begin
		if (reset) begin
			chan_q <= acc_pkg::CHAN_RESET;
		end else if (wr_en & (idx == acc_pkg::IDX_CHAN)) begin
			chan_q <= wdat;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			free_run_q <= acc_pkg::BYTE_RESET[acc_pkg::TRIG_FREE_BIT];
		end else if (wr_en & (idx == acc_pkg::IDX_TRIG)) begin
			free_run_q <= wdat[acc_pkg::TRIG_FREE_BIT];
		end
	end

	// ****************************************************************
	// Converter clock enable and trigger edge.
	// ****************************************************************
	always_ff @(posedge mclk) begin
		if (reset) begin
			div_q <= 8'h00;
		end else if (div_q == 8'(ADC_CLK_DIV - 1)) begin
			div_q <= 8'h00;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end

	assign tick = (div_q == 8'(ADC_CLK_DIV - 1));

	always_ff @(posedge mclk) begin
		if (reset) begin
			trig_meta_q <= 1'b0;
			trig_sync_q <= 1'b0;
			trig_prev_q <= 1'b0;
		end else begin
			trig_meta_q <= trigger_in;
			trig_sync_q <= trig_meta_q;
			trig_prev_q <= trig_sync_q;
		end
	end

	assign trig_edge = trig_sync_q & ~trig_prev_q;

	// ****************************************************************
	// Conversion engine.
	// ****************************************************************
	assign busy       = (state_q == acc_pkg::ST_CONVERT);
	assign en_next    = wr_csr ? wdat[acc_pkg::CSR_EN_BIT] : en_q;
	assign en_rise    = en_next & ~en_q;
	assign abort      = busy & ~en_next; // [RULE13]
	assign finish     = busy & tick & (cnt_q == len_q - 5'h01) & ~abort;
	// A zero in the start bit is simply not a request.
	assign sw_start   = wr_csr & wdat[acc_pkg::CSR_START_BIT]; // [RULE14] [RULE16]
	assign auto_start = auto_q & ~free_run_q & trig_edge; // [RULE18]
	// Free running chains the next conversion onto the end of the previous one.
	assign free_start = auto_q & free_run_q & finish; // [RULE14]
	assign start_go   = en_next & (((sw_start | auto_start) & (~busy | finish)) | free_start);

	always_ff @(posedge mclk) begin
		if (reset) begin
			state_q <= acc_pkg::ST_IDLE;
		end else begin
			case (state_q)
				acc_pkg::ST_IDLE: begin
					if (start_go) begin
						state_q <= acc_pkg::ST_CONVERT;
					end
				end
				acc_pkg::ST_CONVERT: begin
					if (abort | (finish & ~start_go)) begin
						state_q <= acc_pkg::ST_IDLE;
					end
				end
				default: begin
					state_q <= acc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			cnt_q <= 5'h00;
		end else if (start_go) begin
			cnt_q <= 5'h00;
		end else if (busy & tick) begin
			cnt_q <= cnt_q + 5'h01;
		end
	end

	// The long first conversion covers a start in the same write that enables.
	always_ff @(posedge mclk) begin
		if (reset) begin
			first_q <= 1'b0;
		end else if (start_go) begin
			first_q <= 1'b0;
		end else if (en_rise) begin
			first_q <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			len_q <= acc_pkg::LEN_NORMAL;
		end else if (start_go) begin
			len_q <= (first_q | en_rise) ? acc_pkg::LEN_FIRST : acc_pkg::LEN_NORMAL; // [RULE15]
		end
	end

	// Set wins over a clear arriving in the same cycle.
	always_ff @(posedge mclk) begin
		if (reset) begin
			done_q <= acc_pkg::CSR_A_RESET[acc_pkg::CSR_DONE_BIT];
		end else if (finish) begin
			done_q <= 1'b1; // [RULE17]
		end else if ((wr_csr & wdat[acc_pkg::CSR_DONE_BIT]) | vector_taken) begin
			done_q <= 1'b0; // [RULE17]
		end
	end

	// Selection tracks the register only while idle or at a start, so it is frozen mid-conversion.
	assign load = ~busy | start_go; // [RULE1]

	acc_mux_decode u_decode (
		.mclk                (mclk),
		.reset               (reset),
		.load                (load),
		.channel_gain_select (chan_q[acc_pkg::SEL_W-1:0]),
		.mux_q               (mux_sel)
	);

	// ****************************************************************
	// Interrupt status.
	// ****************************************************************
	always_ff @(posedge mclk) begin
		if (reset) begin
			stat_q <= '0;
		end else begin
			stat_q <= (stat_q & ~((wr_en & (idx == acc_pkg::IDX_IRQ_CLEAR)) ?
				wdat[acc_pkg::IRQ_W-1:0] : '0)) | {abort, finish};
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			irq_en_q <= '0;
		end else if (wr_en & (idx == acc_pkg::IDX_IRQ_EN)) begin
			irq_en_q <= wdat[acc_pkg::IRQ_W-1:0];
		end
	end

	assign irq = |(stat_q & irq_en_q);

	// ****************************************************************
	// Outputs to the conversion core.
	// ****************************************************************
	always_ff @(posedge mclk) begin
		if (reset) begin
			start_q  <= 1'b0;
			init_q   <= 1'b0;
			finish_q <= 1'b0;
		end else begin
			start_q  <= start_go;
			finish_q <= finish;
			if (start_go) begin
				init_q <= first_q | en_rise;
			end
		end
	end

	assign conv.power = en_q; // [RULE13]
	assign conv.start = start_q;
	assign conv.busy  = busy;
	assign conv.init  = init_q;
	assign conv.done  = finish_q;

endmodule

`default_nettype wire

// File: verification/acc_core_model.sv
`timescale 1ns/100ps
`default_nettype none

module acc_core_model (
	// Clock and reset.
	input wire logic               mclk,
	input wire logic               reset,
	// Control from the block.
	input wire acc_pkg::acc_mux_t  mux_sel,
	input wire acc_pkg::acc_conv_t conv,
	// What the core saw.
	output logic [15:0]            done_cnt,
	output acc_pkg::acc_mux_t      held_sel
);
	// The routing is sampled once per start, so later changes cannot disturb a conversion.
	always_ff @(posedge mclk) begin
		if (reset) begin
			held_sel <= '0;
		end else if (conv.start) begin
			held_sel <= mux_sel;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			done_cnt <= 16'h0000;
		end else if (conv.done) begin
			done_cnt <= done_cnt + 16'h0001;
		end
	end
endmodule

`default_nettype wire

// File: verification/acc_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module acc_monitor #(
	parameter int ADC_CLK_DIV = 2
) (
	// Clock and reset.
	input wire logic               mclk,
	input wire logic               reset,
	// Observed outputs.
	input wire logic               wb_ack_o,
	input wire acc_pkg::acc_mux_t  mux_sel,
	input wire acc_pkg::acc_conv_t conv
);
	// Margins cover divider phase and the free-running restart cycle.
	localparam int LONG_MAX  = 27 * ADC_CLK_DIV;
	localparam int SHORT_MAX = 15 * ADC_CLK_DIV;
	localparam int MIN_LEN   = 11 * ADC_CLK_DIV;
	logic [15:0] busy_cnt_q;

	always_ff @(posedge mclk) begin
		if (reset || conv.start || !conv.busy) begin
			busy_cnt_q <= 16'h0000;
		end else begin
			busy_cnt_q <= busy_cnt_q + 16'h0001;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_mux_frozen: assert property (conv.busy && $past(conv.busy) && !conv.start
		&& !$past(conv.start) |-> $stable(mux_sel)) else $error("selection moved while busy");
	a_temp_sensor: assert property (
		mux_sel.temp_sensor_en == (mux_sel.kind == acc_pkg::KIND_TEMP)) else $error("sensor enable");
	a_offset_same: assert property (mux_sel.kind == acc_pkg::KIND_OFFSET
		|-> mux_sel.pos == mux_sel.neg && mux_sel.pos inside {3'h0, 3'h3, 3'h7})
		else $error("bad offset pair");
	a_start_busy: assert property (conv.start |-> conv.busy)
		else $error("start without busy");
	a_finish_done: assert property ($fell(conv.busy) && conv.power |-> ##[0:2] conv.done)
		else $error("no done pulse");
	a_abort_idle: assert property (!conv.power && !$past(conv.power) |-> !conv.busy)
		else $error("busy while disabled");
	a_len_long: assert property (conv.busy |-> busy_cnt_q <= LONG_MAX)
		else $error("conversion too long");
	a_len_short: assert property (conv.busy && !conv.init |-> busy_cnt_q <= SHORT_MAX)
		else $error("normal conversion too long");
	a_len_min: assert property ($fell(conv.busy) && conv.power |-> $past(busy_cnt_q) >= MIN_LEN)
		else $error("conversion too short");
endmodule

`default_nettype wire

// File: verification/acc_top_tb.sv
`timescale 1ns/100ps
`default_nettype none

module acc_top_tb;
	localparam int CLK_DIV = 1;
	// Normal pairs {positive, negative} indexed by select bits 4:1.
	localparam logic [5:0] PAIRS [16] = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h01, 6'h03, 6'h0a,
		6'h0b, 6'h13, 6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h25, 6'h2e, 6'h37};
	logic               mclk;
	logic               reset;
	logic               wb_cyc_i;
	logic               wb_stb_i;
	logic               wb_we_i;
	logic [7:0]         wb_adr_i;
	logic [3:0]         wb_sel_i;
	logic [31:0]        wb_dat_i;
	logic [31:0]        wb_dat_o;
	logic               wb_ack_o;
	logic               trigger_in;
	logic               vector_taken;
	logic               irq;
	acc_pkg::acc_mux_t  mux_sel;
	acc_pkg::acc_conv_t conv;
	acc_pkg::acc_mux_t  held_sel;
	logic [15:0]        done_cnt;
	int                 fails;
	int                 num_checks;

	acc_top #(.ADC_CLK_DIV(CLK_DIV)) u_dut (.mclk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .trigger_in, .vector_taken,
		.irq, .mux_sel, .conv);
	acc_core_model u_core (.mclk, .reset, .mux_sel, .conv, .done_cnt, .held_sel);

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic end_of_test;
		if (fails == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [11:0] g, input logic [11:0] e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] r);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'h1;
		wb_dat_i <= {24'h000000, d};
		// Only ack or the watchdog ends this wait; the slave's latency is not assumed here.
		do begin
			@(posedge mclk);
		end while (wb_ack_o !== 1'b1);
		r = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		wb(1'b1, a, d, r);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] r;
		wb(1'b0, a, 8'h00, r);
		chk({4'h0, r}, {4'h0, e});
	endtask

	task automatic wait_idle(output int n);
		n = 0;
		while (conv.busy === 1'b1 && n < 500) begin
			@(posedge mclk);
			n++;
		end
		if (conv.busy === 1'b1) begin
			fails++;
			$display("[ERR] %0t conversion never ended", $time);
		end
	endtask

	// ****************************************************************
	// Scenarios.
	// ****************************************************************
	task automatic t_reset_regs;
		rd_chk(8'h18, 8'h00);
		rd_chk(8'h1c, 8'h00);
		rd_chk(8'h3c, 8'h00);
		chk(mux_sel, 12'h000);
	endtask

	task automatic t_decode;
		logic [5:0]  c;
		logic [5:0]  p;
		logic [2:0]  o;
		logic [11:0] e;
		logic [11:0] m;
		for (int i = 0; i < 64; i++) begin
			c = i[5:0];
			p = PAIRS[c[4:1]];
			o = (c < 6'h24) ? 3'h0 : (c < 6'h26) ? 3'h3 : 3'h7;
			m = 12'hfff;
			if (c < 6'h08) begin
				e = {acc_pkg::KIND_SINGLE, c[2:0], 6'h00};
				m = 12'hfc2;
			end else if (c < 6'h20) begin
				e = {acc_pkg::KIND_DIFF, p, c[0], 2'b00};
			end else if (c < 6'h23) begin
				e = {c[1] ? acc_pkg::KIND_TEMP : c[0] ? acc_pkg::KIND_VREF : acc_pkg::KIND_GROUND,
					7'h00, c[1], 1'b0};
				m = 12'he02;
			end else if (c < 6'h28) begin
				e = {acc_pkg::KIND_OFFSET, o, o, c[0], 2'b00};
				m = 12'hffc;
			end else begin
				e = {acc_pkg::KIND_DIFF, p[2:0], p[5:3], c[0], 2'b01};
			end
			// No conversion runs in this loop, so nothing is taken before a new reference settles.
			wr(8'h1c, {2'b00, c});
			@(posedge mclk);
			chk(mux_sel & m, e & m);
		end
	endtask

	task automatic t_long;
		int n;
		wr(8'h18, 8'hc0);
		rd_chk(8'h18, 8'hc0);
		wait_idle(n);
		chk(12'(n >= 25 * CLK_DIV - 8 && n <= 25 * CLK_DIV), 12'h001);
		rd_chk(8'h18, 8'h90);
		rd_chk(8'h24, 8'h01);
	endtask

	task automatic t_short;
		int n;
		wr(8'h18, 8'h90);
		rd_chk(8'h18, 8'h80);
		wr(8'h1c, 8'h08);
		wr(8'h18, 8'hc0);
		wr(8'h1c, 8'h3f);
		chk(mux_sel, {acc_pkg::KIND_DIFF, 9'h008});
		wait_idle(n);
		chk(12'(n >= 13 * CLK_DIV - 8 && n <= 13 * CLK_DIV), 12'h001);
		chk(held_sel, {acc_pkg::KIND_DIFF, 9'h008});
		repeat (2) @(posedge mclk);
		chk(mux_sel, {acc_pkg::KIND_DIFF, 9'h1f5});
	endtask

	task automatic t_abort;
		wr(8'h28, 8'h03);
		wr(8'h18, 8'h90);
		wr(8'h18, 8'hc0);
		wr(8'h18, 8'h00);
		repeat (40) @(posedge mclk);
		rd_chk(8'h18, 8'h00);
		rd_chk(8'h24, 8'h02);
	endtask

	task automatic t_irq;
		int n;
		wr(8'h28, 8'h03);
		wr(8'h2c, 8'h01);
		chk({11'h000, irq}, 12'h000);
		wr(8'h18, 8'hc0);
		wait_idle(n);
		chk(12'(n >= 25 * CLK_DIV - 2 && n <= 25 * CLK_DIV + 2), 12'h001);
		@(posedge mclk);
		chk({11'h000, irq}, 12'h001);
		wr(8'h2c, 8'h00);
		chk({11'h000, irq}, 12'h000);
		wr(8'h2c, 8'h01);
		chk({11'h000, irq}, 12'h001);
		wr(8'h28, 8'h01);
		chk({11'h000, irq}, 12'h000);
		vector_taken <= 1'b1;
		@(posedge mclk);
		vector_taken <= 1'b0;
		@(posedge mclk);
		rd_chk(8'h18, 8'h80);
	endtask

	task automatic t_trigger;
		int n;
		logic [15:0] d0;
		wr(8'h18, 8'hb0);
		trigger_in <= 1'b1;
		wait_idle(n);
		repeat (12) @(posedge mclk);
		chk({11'h000, conv.busy}, 12'h001);
		wait_idle(n);
		trigger_in <= 1'b0;
		repeat (30) @(posedge mclk);
		chk({11'h000, conv.busy}, 12'h000);
		wr(8'h20, 8'h01);
		d0 = done_cnt;
		wr(8'h18, 8'hf0);
		repeat (80) @(posedge mclk);
		chk(12'(done_cnt - d0 >= 16'h0004 && conv.busy === 1'b1), 12'h001);
		wr(8'h18, 8'h00);
		wr(8'h20, 8'h00);
		chk({11'h000, conv.busy}, 12'h000);
	endtask

	initial begin
		reset = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h00000000;
		trigger_in = 1'b0;
		vector_taken = 1'b0;
		fails = 0;
		num_checks = 0;
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		t_reset_regs;
		t_decode;
		t_long;
		t_short;
		t_abort;
		t_irq;
		t_trigger;
		end_of_test;
	end

	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		end_of_test;
	end
endmodule

bind acc_top acc_monitor #(.ADC_CLK_DIV(ADC_CLK_DIV)) u_mon (.mclk(mclk), .reset(reset),
	.wb_ack_o(wb_ack_o), .mux_sel(mux_sel), .conv(conv));

`default_nettype wire
